// >>> rtl/lhb_top.sv
// header break, sync measurement and collision assist for a serial bus
`timescale 1ns/100ps
`include "lhb_defs.svh"
module lhb_top (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic receive_line_in,
   output logic transmit_line_out,
   input wire logic uart_txd_in,
   output logic uart_rxd_out,
   input wire logic uart_latch_strobe,
   output logic uart_tx_valid,
   input wire logic uart_tx_ready,
   output logic [7:0] uart_tx_data,
   output logic timer_irq_req,
   output lhb_pkg::lhb_flags_t flags_out
);
   import lhb_pkg::*;
   // ----------------------------------------
   // state and registers
   // ----------------------------------------
   lhb_state_t st;
   logic [6:0] ctl;
   logic te;
   logic [15:0] pre_reg, cnt_reg, pre_q, cnt_q, meas;
   logic [7:0] ident;
   lhb_flags_t flags;
   logic rx_meta, rx_sync, rx_prev, tx_d1, tx_d2;
   logic [2:0] falls;
   logic wr, rd_setup, hit, arm_wr, start_wr, fall, tick, down_run, under;
   logic brk_set, sync_set, col_set, gate;
   logic [2:0] clr;
   logic [31:0] next_rdata;

   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign arm_wr = wr && paddr == `LHB_OFS_LINCTL && pwdata[`LHB_CTL_ARM];
   assign start_wr = wr && paddr == `LHB_OFS_TIMCTL
      && pwdata[`LHB_TIM_START];
   assign clr = (wr && paddr == `LHB_OFS_LINSTS) ? pwdata[2:0] : 3'h0;

   // ----------------------------------------
   // apb slave, zero wait states
   // ----------------------------------------
   always_comb begin
      hit = 1'b1;
      next_rdata = 32'h0000_0000;
      case (paddr)
         `LHB_OFS_LINCTL: next_rdata[6:0] = ctl;
         `LHB_OFS_LINSTS: next_rdata[2:0] = flags;
         `LHB_OFS_TIMCTL: next_rdata[0] = (st == ST_BRK_GEN);
         `LHB_OFS_TIMPRE: next_rdata[15:0] = pre_reg;
         `LHB_OFS_TIMCNT: next_rdata[15:0] = cnt_reg;
         `LHB_OFS_UCTL1: next_rdata[0] = te;
         `LHB_OFS_IDENT: next_rdata[7:0] = ident;
         `LHB_OFS_MEAS: next_rdata[15:0] = meas;
         default: hit = 1'b0;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= next_rdata;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctl <= `LHB_CTL_RST;
         te <= 1'b0;
         pre_reg <= `LHB_TIM_RST;
         cnt_reg <= `LHB_TIM_RST;
         ident <= `LHB_ID_RST;
      end else if (wr) begin
         case (paddr)
            // arm bit is a strobe, stored as zero
            `LHB_OFS_LINCTL: ctl <= pwdata[6:0] & 7'h7B;
            `LHB_OFS_TIMPRE: pre_reg <= pwdata[15:0];
            `LHB_OFS_TIMCNT: cnt_reg <= pwdata[15:0];
            `LHB_OFS_UCTL1: te <= pwdata[`LHB_UCTL_TE];
            `LHB_OFS_IDENT: ident <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // receive synchroniser
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= receive_line_in;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end
   assign fall = rx_prev && !rx_sync;

   // ----------------------------------------
   // break timer
   // ----------------------------------------
   // low phase lasts (pre+1)*(cnt+1) clocks
   assign tick = (pre_q == 16'h0000);
   assign down_run = (st == ST_BRK_GEN) || (!rx_sync
      && (st == ST_WAIT_BRK || st == ST_COMM));
   assign under = down_run && tick && cnt_q == 16'h0000;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pre_q <= `LHB_TIM_RST;
         cnt_q <= `LHB_TIM_RST;
      end else if (st == ST_WAIT_START) begin
         pre_q <= pre_reg;
         cnt_q <= 16'h0000;
      end else if (st == ST_MEASURE) begin
         pre_q <= tick ? pre_reg : pre_q - 16'h0001;
         if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end else if (down_run) begin
         pre_q <= tick ? pre_reg : pre_q - 16'h0001;
         if (tick) begin
            cnt_q <= under ? cnt_reg : cnt_q - 16'h0001;
         end
      end else begin
         // a high level in ST_WAIT_BRK or ST_COMM restarts the low-run count
         pre_q <= pre_reg;
         cnt_q <= cnt_reg;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   assign sync_set = (st == ST_MEASURE) && fall
      && falls == `LHB_SYNC_LAST_FALL;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st <= ST_IDLE;
         falls <= 3'h0;
         meas <= `LHB_TIM_RST;
         uart_tx_data <= 8'h00;
      end else if (!ctl[`LHB_CTL_EN]) begin
         st <= ST_IDLE;
      end else begin
         case (st)
            ST_IDLE: begin
               if (ctl[`LHB_CTL_MASTER] && start_wr) begin
                  st <= ST_BRK_GEN;
               end else if (!ctl[`LHB_CTL_MASTER] && arm_wr) begin
                  st <= ST_WAIT_BRK;
               end
            end
            ST_BRK_GEN: begin
               if (under) begin
                  st <= ST_TX_SYNC;
                  uart_tx_data <= `LHB_SYNC_BYTE;
               end
            end
            ST_TX_SYNC: begin
               if (uart_tx_ready) begin
                  st <= ST_TX_ID;
                  uart_tx_data <= ident;
               end
            end
            ST_TX_ID: begin
               if (uart_tx_ready) begin
                  st <= ST_COMM;
               end
            end
            ST_WAIT_BRK: begin
               if (under) begin
                  st <= ST_WAIT_HIGH;
               end
            end
            ST_WAIT_HIGH: begin
               if (rx_sync) begin
                  st <= ST_WAIT_START;
               end
            end
            ST_WAIT_START: begin
               if (fall) begin
                  st <= ST_MEASURE;
                  falls <= 3'h0;
               end
            end
            ST_MEASURE: begin
               if (sync_set) begin
                  st <= ST_COMM;
                  // the tick on the closing edge belongs to the span
                  meas <= cnt_q + {15'h0000, tick};
               end else if (fall) begin
                  falls <= falls + 3'h1;
               end
            end
            ST_COMM: begin
               // a slave re-synchronises on a break seen mid-frame
               if (under && !ctl[`LHB_CTL_MASTER]) begin
                  st <= ST_WAIT_HIGH;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end
   assign uart_tx_valid = (st == ST_TX_SYNC) || (st == ST_TX_ID);

   // ----------------------------------------
   // line outputs
   // ----------------------------------------
   assign transmit_line_out = (st == ST_BRK_GEN) ? 1'b0 : uart_txd_in;
   assign gate = (st == ST_WAIT_BRK) || (st == ST_WAIT_HIGH)
      || (st == ST_WAIT_START) || (st == ST_MEASURE);
   // receiver sees idle high when the header is withheld
   assign uart_rxd_out = (gate && !ctl[`LHB_CTL_PASS]) ? 1'b1
      : rx_sync;

   // ----------------------------------------
   // flags and shared interrupt
   // ----------------------------------------
   // driven level delayed to line up with the synchronised input
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_d1 <= 1'b1;
         tx_d2 <= 1'b1;
      end else begin
         tx_d1 <= transmit_line_out;
         tx_d2 <= tx_d1;
      end
   end
   assign brk_set = under;
   assign col_set = te && uart_latch_strobe && rx_sync != tx_d2;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         flags <= '0;
      end else begin
         // set wins over a clear in the same cycle
         flags.brk <= brk_set || (flags.brk && !clr[0]);
         flags.sync_done <= sync_set || (flags.sync_done && !clr[1]);
         flags.collision <= col_set || (flags.collision && !clr[2]);
      end
   end
   assign flags_out = flags;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         timer_irq_req <= 1'b0;
      end else begin
         timer_irq_req <= (brk_set && ctl[`LHB_CTL_BRK_IE])
            || (sync_set && ctl[`LHB_CTL_SYNC_IE])
            || (col_set && ctl[`LHB_CTL_COL_IE]);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence s_arm_enter;
      st == ST_IDLE ##1 st == ST_WAIT_BRK;
   endsequence
   sequence s_brk_end;
      st == ST_BRK_GEN && under;
   endsequence

   AST_BRK_LOW: assert property (
      st == ST_BRK_GEN |-> !transmit_line_out)
      else $error("line not low during break");
   AST_BRK_END: assert property (
      s_brk_end |=> st == ST_TX_SYNC && flags.brk)
      else $error("break did not end with flag");
   AST_BRK_IRQ: assert property (
      brk_set && ctl[`LHB_CTL_BRK_IE] |=> timer_irq_req)
      else $error("break interrupt missing");
   AST_SYNC_BYTE: assert property (
      st == ST_TX_SYNC |-> uart_tx_valid
         && uart_tx_data == `LHB_SYNC_BYTE)
      else $error("sync byte not offered");
   AST_ARM: assert property (
      s_arm_enter |-> $past(arm_wr))
      else $error("break detection armed without write");
   AST_MEAS: assert property (
      sync_set |=> flags.sync_done && st == ST_COMM
         && meas == $past(cnt_q) + {15'h0000, $past(tick)})
      else $error("measurement not captured");
   AST_GATE: assert property (
      gate && !ctl[`LHB_CTL_PASS] |-> uart_rxd_out)
      else $error("sync field leaked to receiver");
   AST_COL_OFF: assert property (
      !te && !flags.collision |=> !flags.collision)
      else $error("collision with transmitter off");
   AST_COL: assert property (
      col_set |=> flags.collision)
      else $error("collision not flagged");
   AST_SYNC2: assert property (
      ##2 rx_sync == $past(receive_line_in, 2))
      else $error("receive path not two stages");
endmodule : lhb_top

// >>> shared/lhb_defs.svh
// register map, field positions, reset values and constants
`ifndef LHB_DEFS_SVH
`define LHB_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LHB_OFS_LINCTL 8'h00
`define LHB_OFS_LINSTS 8'h04
`define LHB_OFS_TIMCTL 8'h08
`define LHB_OFS_TIMPRE 8'h0C
`define LHB_OFS_TIMCNT 8'h10
`define LHB_OFS_UCTL1 8'h14
`define LHB_OFS_IDENT 8'h18
`define LHB_OFS_MEAS 8'h1C
// ----------------------------------------
// control fields
// ----------------------------------------
`define LHB_CTL_EN 0
`define LHB_CTL_MASTER 1
`define LHB_CTL_ARM 2
`define LHB_CTL_PASS 3
`define LHB_CTL_BRK_IE 4
`define LHB_CTL_SYNC_IE 5
`define LHB_CTL_COL_IE 6
`define LHB_CTL_W 7
`define LHB_CTL_RST 7'h00
`define LHB_TIM_START 0
`define LHB_UCTL_TE 0
// ----------------------------------------
// values
// ----------------------------------------
`define LHB_TIM_RST 16'h0000
`define LHB_ID_RST 8'h00
`define LHB_SYNC_BYTE 8'h55
`define LHB_SYNC_LAST_FALL 3'h3
`endif

// >>> shared/lhb_pkg.sv
// types shared by the header assist block
package lhb_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_BRK_GEN, ST_TX_SYNC, ST_TX_ID, ST_WAIT_BRK,
      ST_WAIT_HIGH, ST_WAIT_START, ST_MEASURE, ST_COMM
   } lhb_state_t;
   typedef struct packed {
      logic collision;
      logic sync_done;
      logic brk;
   } lhb_flags_t;
endpackage : lhb_pkg

// >>> tb/lhb_bus_node.sv
// far-side bus node model behind the line transceiver
`timescale 1ns/100ps
module lhb_bus_node (
   input wire logic clock,
   input wire logic transmit_line_out,
   output logic receive_line_in
);
   logic drive_q;
   // ----------------------------------------
   // wired-and bus, recessive high via pull-up
   // ----------------------------------------
   initial drive_q = 1'b1;
   assign receive_line_in = transmit_line_out & drive_q;
   // level changes only just after an edge, held n cycles
   task automatic hold(input logic lvl, input int n);
      drive_q <= lvl;
      repeat (n) @(posedge clock);
   endtask : hold
   // lsb first, low start bit, high stop bit
   task automatic send_byte(input logic [7:0] b, input int bt);
      hold(1'b0, bt);
      for (int i = 0; i < 8; i++) begin
         hold(b[i], bt);
      end
      hold(1'b1, bt);
   endtask : send_byte
endmodule : lhb_bus_node

// >>> tb/lhb_top_test.sv
// self-checking bench for the header assist block
`timescale 1ns/100ps
`include "lhb_defs.svh"
module lhb_top_test;
   import lhb_pkg::*;
   localparam int PRE = 1;
   localparam int CNT = 2;
   localparam int BIT = 12;
   logic clock, rst_b, psel, penable, pwrite, pready, pslverr, perr;
   logic receive_line_in, transmit_line_out, uart_txd_in, uart_rxd_out;
   logic uart_latch_strobe, uart_tx_valid, uart_tx_ready, timer_irq_req;
   logic [7:0] paddr, uart_tx_data;
   logic [31:0] pwdata, prdata, q;
   logic rxd_low;
   lhb_flags_t flags_out;
   int n_errors = 0;
   int comparisons = 0;
   int n_irq = 0;
   int low_n = 0;
   lhb_top dut_u (.clock(clock), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .receive_line_in(receive_line_in),
      .transmit_line_out(transmit_line_out), .uart_txd_in(uart_txd_in),
      .uart_rxd_out(uart_rxd_out), .uart_latch_strobe(uart_latch_strobe),
      .uart_tx_valid(uart_tx_valid), .uart_tx_ready(uart_tx_ready),
      .uart_tx_data(uart_tx_data), .timer_irq_req(timer_irq_req),
      .flags_out(flags_out));
   lhb_bus_node node_u (.clock(clock), .transmit_line_out(transmit_line_out),
      .receive_line_in(receive_line_in));
   // ----------------------------------------
   // clock and monitors
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      if (timer_irq_req === 1'b1) n_irq++;
      if (transmit_line_out === 1'b0) low_n++;
      // after measurement ends the tail of the byte may pass freely
      if (uart_rxd_out === 1'b0 && flags_out.sync_done !== 1'b1) rxd_low = 1;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // idle cycle after each transfer keeps drivers single per step
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic results;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   initial begin
      repeat (30000) @(posedge clock);
      n_errors++;
      results();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      uart_txd_in = 1'b1;
      uart_latch_strobe = 1'b0;
      uart_tx_ready = 1'b0;
      rxd_low = 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      apb(1'b0, `LHB_OFS_LINSTS, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({q[30:0], perr}, 32'h1);
      // master header
      apb(1'b1, `LHB_OFS_TIMPRE, PRE);
      apb(1'b1, `LHB_OFS_TIMCNT, CNT);
      apb(1'b1, `LHB_OFS_IDENT, 32'hA3);
      apb(1'b1, `LHB_OFS_LINCTL, 32'h13);
      low_n = 0;
      apb(1'b1, `LHB_OFS_TIMCTL, 32'h1);
      for (int i = 0; i < 60 && uart_tx_valid !== 1'b1; i++) begin
         @(posedge clock);
      end
      chk(low_n, (PRE + 1) * (CNT + 1));
      chk({29'h0, flags_out}, 32'h1);
      chk({24'h0, uart_tx_data}, 32'h55);
      uart_tx_ready <= 1'b1;
      @(posedge clock);
      uart_tx_ready <= 1'b0;
      @(posedge clock);
      chk({23'h0, uart_tx_valid, uart_tx_data}, 32'h1A3);
      uart_tx_ready <= 1'b1;
      @(posedge clock);
      uart_tx_ready <= 1'b0;
      @(posedge clock);
      chk({31'h0, uart_tx_valid}, 32'h0);
      chk(n_irq, 1);
      // slave header, sync withheld then passed
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, `LHB_OFS_LINCTL, 32'h0);
         apb(1'b1, `LHB_OFS_LINSTS, 32'h7);
         apb(1'b1, `LHB_OFS_LINCTL, {26'h0, 2'h2, p[0], 3'h1});
         n_irq = 0;
         node_u.hold(1'b0, 20);
         node_u.hold(1'b1, 4);
         chk({29'h0, flags_out}, 32'h0);
         apb(1'b1, `LHB_OFS_LINCTL, {26'h0, 2'h2, p[0], 3'h5});
         apb(1'b0, `LHB_OFS_LINCTL, 32'h0);
         chk(q, {26'h0, 2'h2, p[0], 3'h1});
         rxd_low = 1'b0;
         node_u.hold(1'b0, 20);
         node_u.hold(1'b1, BIT);
         chk({29'h0, flags_out}, 32'h1);
         node_u.send_byte(8'h55, BIT);
         chk({29'h0, flags_out}, 32'h3);
         chk(n_irq, 1);
         apb(1'b0, `LHB_OFS_MEAS, 32'h0);
         chk(q, 8 * BIT / (PRE + 1));
         chk({31'h0, rxd_low}, p);
         apb(1'b1, `LHB_OFS_TIMCNT, CNT);
      end
      // long low during traffic
      apb(1'b1, `LHB_OFS_LINSTS, 32'h7);
      node_u.hold(1'b0, 20);
      node_u.hold(1'b1, BIT);
      chk({31'h0, flags_out.brk}, 32'h1);
      // collision, transmitter off then on
      for (int t = 0; t < 2; t++) begin
         apb(1'b1, `LHB_OFS_LINCTL, 32'h0);
         apb(1'b1, `LHB_OFS_LINSTS, 32'h7);
         apb(1'b1, `LHB_OFS_UCTL1, t);
         apb(1'b1, `LHB_OFS_LINCTL, 32'h1);
         node_u.hold(1'b0, 4);
         uart_latch_strobe <= 1'b1;
         @(posedge clock);
         uart_latch_strobe <= 1'b0;
         node_u.hold(1'b1, 4);
         chk({31'h0, flags_out.collision}, t);
      end
      results();
   end
endmodule : lhb_top_test
